// [poll_pkg.sv]
/*
  shared constants and types for the poll / control link between the
  fieldbus master end and the sensor end.
  assumes a single 40 MHz clock shared by both ends.
*/
`default_nettype none
package poll_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned PRESET_GAP_MS = 500; // least spacing of presets
  localparam int unsigned PRESET_GAP_CYC = PRESET_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned DUP_CHECK_COUNT = 2; // duplicate address messages sent
  localparam int unsigned WDOG_W = 24; // width of the watchdog counter
  localparam int unsigned BLINK_W = 22; // blink divider width

  // control byte layout
  localparam int unsigned CTL_PRESET = 0;
  localparam int unsigned CTL_DIODE_OFF = 1;
  localparam int unsigned CTL_DIODE_ON = 2;
  localparam int unsigned CTL_CLEAR = 3;
  localparam logic [7:0] CTL_UNUSED_MASK = 8'hf0;

  // message kinds on the link
  typedef enum logic [2:0] {
    MSG_POLL = 3'h0, // poll command, data = control byte
    MSG_READ = 3'h1, // explicit read, addr = attribute
    MSG_WRITE = 3'h2, // explicit write
    MSG_OPEN = 3'h3, // unconnected explicit: open io connection
    MSG_CLOSE = 3'h4, // unconnected explicit: close io connection
    MSG_DUP = 3'h5 // duplicate address check (device to master)
  } msg_e;

  // explicit response status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_BAD_ATTR = 8'h14;
  localparam logic [7:0] ST_NO_CONN = 8'h0c;

  // attribute numbers reachable by explicit messages
  localparam logic [7:0] ATTR_PRESET = 8'h05;
  localparam logic [7:0] ATTR_EXT_FUNC = 8'h0a;
  localparam logic [7:0] ATTR_AUTO_ACK = 8'h0b;
  localparam logic [7:0] ATTR_WDOG = 8'h0c;
  localparam logic [7:0] ATTR_AUTO_OFF = 8'h0d;
  localparam logic [7:0] EXT_FUNC_DIODE = 8'h02; // external input = diode switch

  // master register map (apb, byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00; // [0] go, [3:1] kind
  localparam logic [7:0] REG_ARG = 8'h04; // [7:0] addr, [31:8] data
  localparam logic [7:0] REG_RESP = 8'h08; // last response data
  localparam logic [7:0] REG_STAT = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] REG_MASK = 8'h10; // interrupt mask
  localparam int unsigned EV_RESP = 0;
  localparam int unsigned EV_DUP = 1;
  localparam int unsigned EV_REFUSED = 2;
  localparam int unsigned EV_W = 3;
endpackage
`default_nettype wire

// [poll_link_if.sv]
/*
  link between the master end and the sensor end: a request channel and an
  answer channel, each a one-cycle valid strobe with its payload.
  assumes both ends sit on the same clock.
*/
`default_nettype none
interface poll_link_if;
  import poll_pkg::*;
  logic req_valid; // one-cycle request strobe
  msg_e req_kind;
  logic [7:0] req_addr; // attribute number
  logic [31:0] req_data; // control byte or write data
  logic rsp_valid; // one-cycle answer strobe
  msg_e rsp_kind;
  logic [7:0] rsp_status;
  logic [31:0] rsp_data; // four input bytes or read data
  modport master (output req_valid, req_kind, req_addr, req_data,
                  input rsp_valid, rsp_kind, rsp_status, rsp_data);
  modport device (input req_valid, req_kind, req_addr, req_data,
                  output rsp_valid, rsp_kind, rsp_status, rsp_data);
endinterface
`default_nettype wire

// [poll_device.sv]
/*
  sensor end: answers polls with the four input bytes, decodes the control
  byte on rising bits, serves attribute reads and writes, opens and closes
  the io connection and supervises it with a watchdog.
  assumes the master end keeps one request outstanding and polls each slave
  on its own; position and error cause come from the measuring core.
*/
// Contract
// - master polls each slave by own command
// - poll answered with current input data
// - explicit requests answered with service result
// - connections change only by unconnected explicit; here a watchdog timeout also drops one
// - duplicate address check sent after power-up
// - control byte bits: preset, off, on, clear
// - commands act on rising bit only
// - preset makes position equal preset value
// - presets spaced at least 500 ms
// - diode off unless external or automatic switching
// - diode on under same exclusions
// - clear error when acknowledge not automatic
// - watchdog drops connection, red led flashes
`default_nettype none
module poll_device
  import poll_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  poll_link_if.device link,
  input wire logic [23:0] raw_position, // physical position
  input wire logic [7:0] error_cause, // live error sources, nonzero = fault
  output logic laser_diode, // laser diode enable
  output logic error_flag, // pending error report
  output logic red_led, // error indicator
  output logic online // io connection established
);
  import poll_pkg::*;

  typedef enum logic [2:0] {
    S_DUP = 3'b001, // sending duplicate address checks
    S_IDLE = 3'b010, // online, no io connection
    S_CONN = 3'b100 // io connection established
  } dev_state_e;

  dev_state_e state_reg, state_next;
  logic [1:0] dup_cnt_reg, dup_cnt_next;
  logic [7:0] ctl_prev_reg, ctl_prev_next; // last control byte, for edges
  logic [23:0] offset_reg, offset_next; // preset correction
  logic [23:0] preset_val_reg, preset_val_next;
  logic [7:0] ext_func_reg, ext_func_next;
  logic auto_ack_reg, auto_ack_next;
  logic auto_off_reg, auto_off_next;
  logic [WDOG_W-1:0] wdog_set_reg, wdog_set_next; // zero = no supervision
  logic [WDOG_W-1:0] wdog_reg, wdog_next;
  logic timed_out_reg, timed_out_next;
  logic [BLINK_W-1:0] blink_reg, blink_next;
  logic diode_reg, diode_next;
  logic err_reg, err_next;
  logic rv_reg, rv_next;
  msg_e rk_reg, rk_next;
  logic [7:0] rs_reg, rs_next;
  logic [31:0] rd_reg, rd_next;
  logic led_reg, led_next;
  logic online_reg, online_next; // registered connected state, feeds the pin
  logic [23:0] position; // corrected position
  logic [7:0] rise; // rising control bits
  logic diode_locked; // diode commands ignored

  assign position = raw_position + offset_reg;
  assign diode_locked = (ext_func_reg == EXT_FUNC_DIODE) || auto_off_reg;

  // next-state logic for the whole end
  always_comb begin
    state_next = state_reg;
    dup_cnt_next = dup_cnt_reg;
    ctl_prev_next = ctl_prev_reg;
    offset_next = offset_reg;
    preset_val_next = preset_val_reg;
    ext_func_next = ext_func_reg;
    auto_ack_next = auto_ack_reg;
    auto_off_next = auto_off_reg;
    wdog_set_next = wdog_set_reg;
    wdog_next = wdog_reg;
    timed_out_next = timed_out_reg;
    // divider starts at the timeout, so the indicator lights at once
    blink_next = timed_out_reg ? blink_reg + 1'b1 : '0;
    diode_next = diode_reg;
    rv_next = 1'b0;
    rk_next = rk_reg;
    rs_next = rs_reg;
    rd_next = rd_reg;
    rise = 8'h00;
    // cause still present after a clear sets the report again
    err_next = err_reg | (error_cause != 8'h00);
    unique case (state_reg)
      S_DUP: begin
        // announce the node before taking part in traffic
        rv_next = 1'b1;
        rk_next = MSG_DUP;
        rs_next = ST_OK;
        rd_next = 32'h0000_0000;
        dup_cnt_next = dup_cnt_reg + 2'd1;
        if (dup_cnt_reg == 2'(DUP_CHECK_COUNT - 1)) begin
          state_next = S_IDLE;
        end
      end
      S_IDLE, S_CONN: begin
        // watchdog runs only while connected and armed
        if (state_reg == S_CONN && wdog_set_reg != '0) begin
          if (wdog_reg == '0) begin
            state_next = S_IDLE;
            timed_out_next = 1'b1;
          end else begin
            wdog_next = wdog_reg - 1'b1;
          end
        end
        if (link.req_valid) begin
          rv_next = 1'b1;
          rk_next = link.req_kind;
          rs_next = ST_OK;
          rd_next = 32'h0000_0000;
          unique case (link.req_kind)
            MSG_POLL: begin
              if (state_reg == S_CONN) begin
                wdog_next = wdog_set_reg;
                rise = link.req_data[7:0] & ~ctl_prev_reg & ~CTL_UNUSED_MASK;
                ctl_prev_next = link.req_data[7:0];
                if (rise[CTL_PRESET]) begin
                  offset_next = preset_val_reg - raw_position;
                end
                if (rise[CTL_DIODE_OFF] && !diode_locked) begin
                  diode_next = 1'b0;
                end
                if (rise[CTL_DIODE_ON] && !diode_locked) begin
                  diode_next = 1'b1;
                end
                if (rise[CTL_CLEAR] && !auto_ack_reg) begin
                  err_next = 1'b0;
                end
                // byte 3 shows error status while an error is pending
                rd_next = err_reg ? {error_cause, position} : {8'h00, position};
              end else begin
                rs_next = ST_NO_CONN; // poll without connection
              end
            end
            MSG_READ: begin
              unique case (link.req_addr)
                ATTR_PRESET: rd_next = {8'h00, preset_val_reg};
                ATTR_EXT_FUNC: rd_next = {24'h0, ext_func_reg};
                ATTR_AUTO_ACK: rd_next = {31'h0, auto_ack_reg};
                ATTR_WDOG: rd_next = {8'h00, wdog_set_reg};
                ATTR_AUTO_OFF: rd_next = {31'h0, auto_off_reg};
                default: rs_next = ST_BAD_ATTR;
              endcase
            end
            MSG_WRITE: begin
              unique case (link.req_addr)
                ATTR_PRESET: preset_val_next = link.req_data[23:0];
                ATTR_EXT_FUNC: ext_func_next = link.req_data[7:0];
                ATTR_AUTO_ACK: auto_ack_next = link.req_data[0];
                ATTR_WDOG: wdog_set_next = link.req_data[WDOG_W-1:0];
                ATTR_AUTO_OFF: auto_off_next = link.req_data[0];
                default: rs_next = ST_BAD_ATTR;
              endcase
            end
            MSG_OPEN: begin
              state_next = S_CONN;
              wdog_next = wdog_set_reg;
              timed_out_next = 1'b0;
              ctl_prev_next = 8'h00;
            end
            MSG_CLOSE: begin
              state_next = S_IDLE;
            end
            default: rs_next = ST_BAD_ATTR; // kinds a master may not send
          endcase
        end
      end
      default: state_next = S_DUP;
    endcase
    // red indicator flashes after a timeout until reconnection, lit first
    led_next = timed_out_next & ~blink_reg[BLINK_W-1];
    // pin shows the connection from a flop, not from a decode
    online_next = (state_next == S_CONN);
  end

  // register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_DUP;
      dup_cnt_reg <= 2'd0;
      ctl_prev_reg <= 8'h00;
      offset_reg <= 24'h000000;
      preset_val_reg <= 24'h000000;
      ext_func_reg <= 8'h00;
      auto_ack_reg <= 1'b1;
      auto_off_reg <= 1'b0;
      wdog_set_reg <= '0;
      wdog_reg <= '0;
      timed_out_reg <= 1'b0;
      blink_reg <= '0;
      diode_reg <= 1'b1;
      err_reg <= 1'b0;
      rv_reg <= 1'b0;
      rk_reg <= MSG_POLL;
      rs_reg <= 8'h00;
      rd_reg <= 32'h0000_0000;
      led_reg <= 1'b0;
      online_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dup_cnt_reg <= dup_cnt_next;
      ctl_prev_reg <= ctl_prev_next;
      offset_reg <= offset_next;
      preset_val_reg <= preset_val_next;
      ext_func_reg <= ext_func_next;
      auto_ack_reg <= auto_ack_next;
      auto_off_reg <= auto_off_next;
      wdog_set_reg <= wdog_set_next;
      wdog_reg <= wdog_next;
      timed_out_reg <= timed_out_next;
      blink_reg <= blink_next;
      diode_reg <= diode_next;
      err_reg <= err_next;
      rv_reg <= rv_next;
      rk_reg <= rk_next;
      rs_reg <= rs_next;
      rd_reg <= rd_next;
      led_reg <= led_next;
      online_reg <= online_next;
    end
  end

  assign link.rsp_valid = rv_reg;
  assign link.rsp_kind = rk_reg;
  assign link.rsp_status = rs_reg;
  assign link.rsp_data = rd_reg;
  assign laser_diode = diode_reg;
  assign error_flag = err_reg;
  assign red_led = led_reg;
  assign online = online_reg;
endmodule
`default_nettype wire

// [poll_master.sv]
/*
  master end: software writes a request into apb registers, the end sends
  it on the link, waits for the answer and stores it; presets are spaced.
  assumes one sensor on the link and a single clock.
*/
`default_nettype none
module poll_master
  import poll_pkg::*;
#(
  parameter int unsigned PRESET_GAP = PRESET_GAP_CYC // shorten in simulation
)
(
  input wire logic clk,
  input wire logic arst_n,
  poll_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import poll_pkg::*;

  logic busy_reg, busy_next; // request outstanding
  logic [2:0] kind_reg, kind_next;
  logic [31:0] arg_reg, arg_next;
  logic [31:0] resp_reg, resp_next;
  logic [EV_W-1:0] stat_reg, stat_next, ev;
  logic [EV_W-1:0] mask_reg, mask_next;
  logic [31:0] gap_reg, gap_next; // preset spacing counter
  logic rv_reg, rv_next;
  logic [31:0] prd_reg, prd_next;
  logic irq_reg, irq_next;
  logic wr, rd, go, preset_req;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  assign go = wr && paddr == REG_CTRL && pwdata[0] && !busy_reg;
  assign preset_req = (msg_e'(pwdata[3:1]) == MSG_POLL) && arg_reg[8 + CTL_PRESET];

  // request, answer and event logic
  always_comb begin
    busy_next = busy_reg;
    kind_next = kind_reg;
    arg_next = arg_reg;
    resp_next = resp_reg;
    mask_next = mask_reg;
    rv_next = 1'b0;
    ev = '0;
    gap_next = (gap_reg != 32'd0) ? gap_reg - 32'd1 : 32'd0;
    prd_next = prd_reg;
    if (wr && paddr == REG_ARG) arg_next = pwdata;
    if (wr && paddr == REG_MASK) mask_next = pwdata[EV_W-1:0];
    if (go) begin
      // refuse a preset that comes too soon
      if (preset_req && gap_reg != 32'd0) begin
        ev[EV_REFUSED] = 1'b1;
      end else begin
        busy_next = 1'b1; // one command per slave per poll
        kind_next = pwdata[3:1];
        rv_next = 1'b1;
        if (preset_req) gap_next = PRESET_GAP;
      end
    end
    if (link.rsp_valid) begin
      if (link.rsp_kind == MSG_DUP) begin
        ev[EV_DUP] = 1'b1;
      end else if (busy_reg) begin
        busy_next = 1'b0;
        resp_next = link.rsp_data;
        ev[EV_RESP] = 1'b1;
      end
    end
    // set wins over write-one-to-clear
    stat_next = (stat_reg & ~((wr && paddr == REG_STAT) ? pwdata[EV_W-1:0] : '0)) | ev;
    irq_next = |(stat_next & mask_next);
    if (rd) begin
      unique case (paddr)
        REG_CTRL: prd_next = {28'h0, kind_reg, busy_reg};
        REG_ARG: prd_next = arg_reg;
        REG_RESP: prd_next = resp_reg;
        REG_STAT: prd_next = {29'h0, stat_reg};
        REG_MASK: prd_next = {29'h0, mask_reg};
        default: prd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg <= 1'b0;
      kind_reg <= 3'h0;
      arg_reg <= 32'h0000_0000;
      resp_reg <= 32'h0000_0000;
      stat_reg <= '0;
      mask_reg <= '0;
      gap_reg <= 32'h0000_0000;
      rv_reg <= 1'b0;
      prd_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      kind_reg <= kind_next;
      arg_reg <= arg_next;
      resp_reg <= resp_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      gap_reg <= gap_next;
      rv_reg <= rv_next;
      prd_reg <= prd_next;
      irq_reg <= irq_next;
    end
  end

  assign link.req_valid = rv_reg;
  assign link.req_kind = msg_e'(kind_reg);
  assign link.req_addr = arg_reg[7:0];
  assign link.req_data = {8'h00, arg_reg[31:8]};
  assign prdata = prd_reg;
  assign pready = 1'b1; // one access phase per transfer
  assign pslverr = 1'b0;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// [poll_asserts.sv]
/*
  link checker: watches the request and answer channels between the ends.
  assumes one clock and the active-low asynchronous reset of both ends.
*/
`default_nettype none
module poll_asserts
  import poll_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire poll_pkg::msg_e req_kind,
  input wire logic [7:0] req_addr,
  input wire logic [31:0] req_data,
  input wire logic rsp_valid,
  input wire poll_pkg::msg_e rsp_kind,
  input wire logic [7:0] rsp_status,
  input wire logic [31:0] rsp_data
);
  import poll_pkg::*;
  // one domain, so one clock and one reset for every property
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // every request is answered on the very next cycle
  a_poll_answer: assert property (req_valid && req_kind == MSG_POLL
    |=> rsp_valid && rsp_kind == MSG_POLL) else $error("poll left unanswered");
  a_read_answer: assert property (req_valid && req_kind == MSG_READ
    |=> rsp_valid && rsp_kind == MSG_READ) else $error("read left unanswered");
  a_write_answer: assert property (req_valid && req_kind == MSG_WRITE
    |=> rsp_valid && rsp_kind == MSG_WRITE) else $error("write left unanswered");
  a_open_answer: assert property (req_valid && req_kind == MSG_OPEN
    |=> rsp_valid && rsp_kind == MSG_OPEN) else $error("open left unanswered");
  a_close_answer: assert property (req_valid && req_kind == MSG_CLOSE
    |=> rsp_valid && rsp_kind == MSG_CLOSE) else $error("close left unanswered");
  // an answer other than the address check always has a request behind it
  a_no_stray: assert property (rsp_valid && rsp_kind != MSG_DUP |-> $past(req_valid))
    else $error("answer without request");
  // the master keeps a single request outstanding
  a_one_outstanding: assert property (req_valid |=> !req_valid [*2])
    else $error("request while one is pending");
  // address check goes out right after reset is released
  a_dup_check: assert property ($rose(arst_n) |-> ##[0:3] (rsp_valid && rsp_kind == MSG_DUP))
    else $error("no address check after reset");
  // the unused control bits travel as zero
  a_unused_zero: assert property (req_valid && req_kind == MSG_POLL
    |-> (req_data[7:0] & CTL_UNUSED_MASK) == 8'h00) else $error("unused control bits set");
endmodule
`default_nettype wire

// [tb.sv]
/*
  testbench: drives the master end over apb and the sensor inputs, and
  judges registers, link answers and sensor outputs.
  assumes the package constants and a 40 MHz clock.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import poll_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic laser_diode, error_flag, red_led, online;
  logic [7:0] paddr, error_cause;
  logic [7:0] last_status; // status of the latest link answer
  logic [31:0] pwdata, prdata, q;
  logic [23:0] raw_position;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  poll_link_if link();
  // short preset gap keeps the run brief
  poll_master #(.PRESET_GAP(200)) poll_master_i (.clk(clk), .arst_n(arst_n), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  poll_device poll_device_i (.clk(clk), .arst_n(arst_n), .link(link),
    .raw_position(raw_position), .error_cause(error_cause), .laser_diode(laser_diode),
    .error_flag(error_flag), .red_led(red_led), .online(online));
  poll_asserts poll_asserts_i (.clk(clk), .arst_n(arst_n), .req_valid(link.req_valid),
    .req_kind(link.req_kind), .req_addr(link.req_addr), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_kind(link.rsp_kind), .rsp_status(link.rsp_status),
    .rsp_data(link.rsp_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // keep the last answer status, it is not visible over apb
  always @(posedge clk) begin
    if (link.rsp_valid === 1'b1) last_status <= link.rsp_status;
  end

  // hang guard: far above what the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task results;
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; read data lands in q; an idle cycle follows
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // issue one link request and fetch its answer data into q
  task req(input msg_e k, input logic [7:0] a, input logic [23:0] d);
    apb(1'b1, REG_ARG, {d, a});
    apb(1'b1, REG_CTRL, {28'h0, k, 1'b1});
    // wait for the answer; only the hang guard ends a lost one
    do begin
      apb(1'b0, REG_CTRL, 32'h0);
    end while (q[0] !== 1'b0);
    apb(1'b0, REG_RESP, 32'h0);
  endtask

  task p(input logic [7:0] c);
    req(MSG_POLL, 8'h00, {16'h0, c});
  endtask

  task t_startup;
    apb(1'b0, REG_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    p(8'h00);
    chk(32'(last_status), 32'(ST_NO_CONN));
    req(MSG_OPEN, 8'h00, 24'h0);
    chk(32'(online), 32'h1);
  endtask

  task t_attr;
    req(MSG_WRITE, ATTR_PRESET, 24'h001234);
    chk(32'(last_status), 32'(ST_OK));
    req(MSG_READ, ATTR_PRESET, 24'h0);
    chk(q, 32'h00001234);
    req(MSG_READ, 8'h77, 24'h0);
    chk(32'(last_status), 32'(ST_BAD_ATTR));
    chk(32'(pslverr), 32'h0);
  endtask

  // preset, its spacing, edge triggering and the refusal interrupt
  task t_preset;
    raw_position <= 24'h000100;
    p(8'h00);
    chk(q, 32'h00000100);
    p(8'h01);
    raw_position <= 24'h000200;
    p(8'h00);
    chk(q, 32'h00001334);
    // only the refusal event may raise the interrupt
    apb(1'b1, REG_MASK, 32'h4);
    apb(1'b1, REG_STAT, 32'h7);
    p(8'h01);
    w(3);
    chk(32'(irq), 32'h1);
    apb(1'b0, REG_STAT, 32'h0);
    chk(q & 32'h4, 32'h4);
    apb(1'b1, REG_STAT, 32'h4);
    w(3);
    chk(32'(irq), 32'h0);
    apb(1'b0, REG_STAT, 32'h0);
    chk(q & 32'h4, 32'h0);
    w(250);
    p(8'h01);
    raw_position <= 24'h000300;
    w(250);
    // held bit must not preset again; the next poll shows the offset
    p(8'h01);
    p(8'h00);
    chk(q, 32'h00001334);
  endtask

  task t_diode;
    p(8'h02);
    chk(32'(laser_diode), 32'h0);
    p(8'h04);
    chk(32'(laser_diode), 32'h1);
    req(MSG_WRITE, ATTR_EXT_FUNC, {16'h0, EXT_FUNC_DIODE});
    p(8'h02);
    chk(32'(laser_diode), 32'h1);
    req(MSG_WRITE, ATTR_EXT_FUNC, 24'h0);
    p(8'h00);
    p(8'h02);
    req(MSG_WRITE, ATTR_EXT_FUNC, {16'h0, EXT_FUNC_DIODE});
    p(8'h04);
    chk(32'(laser_diode), 32'h0);
    req(MSG_WRITE, ATTR_EXT_FUNC, 24'h0);
    // automatic switch-off locks the commands as well
    p(8'h00);
    p(8'h04);
    req(MSG_WRITE, ATTR_AUTO_OFF, 24'h1);
    p(8'h02);
    chk(32'(laser_diode), 32'h1);
    req(MSG_WRITE, ATTR_AUTO_OFF, 24'h0);
  endtask

  task t_error;
    req(MSG_WRITE, ATTR_AUTO_ACK, 24'h0);
    error_cause <= 8'h04;
    p(8'h00);
    chk(32'(q[31:24]), 32'h4);
    p(8'h08);
    w(3);
    chk(32'(error_flag), 32'h1);
    error_cause <= 8'h00;
    p(8'h00);
    chk(32'(error_flag), 32'h1);
    p(8'h08);
    chk(32'(error_flag), 32'h0);
    // with automatic acknowledge the clear bit has no effect
    req(MSG_WRITE, ATTR_AUTO_ACK, 24'h1);
    error_cause <= 8'h01;
    p(8'h00);
    error_cause <= 8'h00;
    p(8'h08);
    chk(32'(error_flag), 32'h1);
  endtask

  // watchdog drops the connection; reopen then close by message
  task t_wdog;
    req(MSG_WRITE, ATTR_WDOG, 24'd60);
    p(8'h00);
    w(100);
    chk(32'(online), 32'h0);
    chk(32'(red_led), 32'h1);
    p(8'h00);
    chk(32'(last_status), 32'(ST_NO_CONN));
    req(MSG_OPEN, 8'h00, 24'h0);
    chk(32'(online), 32'h1);
    chk(32'(red_led), 32'h0);
    req(MSG_CLOSE, 8'h00, 24'h0);
    chk(32'(online), 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_position = 24'h0;
    error_cause = 8'h00;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    w(5);
    t_startup();
    t_attr();
    t_preset();
    t_diode();
    t_error();
    t_wdog();
    results();
  end
endmodule
`default_nettype wire
